// ===== rtl/smp_pkg.sv
/*
 * smp_pkg: constants, types and the rule digest for the static memory pin control.
 * Assumes a single 10 MHz clock and a synchronous active-high reset.
 */
// How it works
// - wait low stretches the access until released
// - assert select of the addressed bank only
// - output enable low during static reads
// - only written byte lanes strobe, never SDRAM
// - output-enable pin during reset gives watchdog polarity
// - two LED pins during reset give bank-0 width
// - boot bank static accesses use the latched width, not I/O ones
package smp_pkg;
    localparam int smp_banks = 2;
    localparam int smp_lanes = 4;
    localparam int smp_addr_w = 26;
    localparam int smp_cnt_w = 4;
    // address bit that picks bank 1 over bank 0
    localparam int smp_bank_bit = 25;
    localparam logic [1:0] smp_width_byte = 2'h1;
    localparam logic [1:0] smp_width_half = 2'h2;
    localparam logic [1:0] smp_width_word = 2'h3;
    localparam logic [1:0] smp_width_rsvd = 2'h0;
    localparam logic [3:0] smp_lanes_none = 4'h0;
    localparam logic [3:0] smp_lanes_byte = 4'h1;
    localparam logic [3:0] smp_lanes_half = 4'h3;
    localparam logic [3:0] smp_lanes_word = 4'hf;
    localparam logic [3:0] smp_cnt_one = 4'h1;
    localparam logic [3:0] smp_cnt_zero = 4'h0;

    typedef enum logic [2:0] {
        smp_idle = 3'h1,
        smp_active = 3'h2,
        smp_done = 3'h4
    } smp_state_t;

    // lanes a boot-bank access may touch for a given strapped width
    function automatic logic [3:0] smp_width_lanes(input logic [1:0] width);
        case (width)
            smp_width_byte: smp_width_lanes = smp_lanes_byte;
            smp_width_half: smp_width_lanes = smp_lanes_half;
            smp_width_word: smp_width_lanes = smp_lanes_word;
            default: smp_width_lanes = smp_lanes_word;
        endcase
    endfunction : smp_width_lanes
endpackage : smp_pkg

// ===== rtl/smp_static_pins.sv
/*
 * smp_static_pins: static memory and external I/O pin control with reset straps.
 * Assumes a requester on clk issuing one access at a time, and tri-state pads
 * outside that combine out/oe pairs.
 */
`timescale 1ns/10ps
`default_nettype none
module smp_static_pins
    import smp_pkg::*;
#(
    parameter int addr_w = smp_addr_w,
    parameter int cnt_w = smp_cnt_w
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [addr_w-1:0] req_addr,
    input wire logic req_write,
    input wire logic req_is_io,
    input wire logic req_is_sdram,
    input wire logic [3:0] req_byte_en,
    input wire logic [cnt_w-1:0] req_wait_cycles,
    output logic done,
    input wire logic ext_wait_n,
    output logic [1:0] static_bank_select_n,
    output logic static_output_enable_n_out,
    output logic static_output_enable_n_oe,
    input wire logic static_output_enable_n_in,
    input wire logic [1:0] indicator_in,
    output logic [1:0] indicator_out,
    output logic [1:0] indicator_oe,
    input wire logic [1:0] led_drive,
    output logic [3:0] byte_lane_write_strobe_n,
    output logic wdog_reset_polarity_strap,
    output logic [1:0] boot_bank_width_strap,
    output logic boot_width_reserved,
    output logic [3:0] boot_lane_mask
);
    smp_strap_if straps ();
    smp_state_t state;
    logic wait_s1, wait_s2, oe_s1, oe_s2;
    logic [1:0] led_s1, led_s2;
    logic [cnt_w-1:0] count;
    logic cur_write, cur_bank;
    logic [3:0] cur_lanes;

    always_ff @(posedge clk)
    begin
        wait_s1 <= ext_wait_n;
        wait_s2 <= wait_s1;
        oe_s1 <= static_output_enable_n_in;
        oe_s2 <= oe_s1;
        led_s1 <= indicator_in;
        led_s2 <= led_s1;
    end

    smp_strap_sampler u_straps (
        .clk(clk),
        .reset(reset),
        .oe_pin_sync(oe_s2),
        .led_pins_sync(led_s2),
        .straps(straps)
    );

    assign wdog_reset_polarity_strap = straps.wdog_reset_polarity_strap;
    assign boot_bank_width_strap = straps.boot_bank_width_strap;
    assign boot_width_reserved = straps.width_reserved;
    assign boot_lane_mask = smp_width_lanes(straps.boot_bank_width_strap);

    // sdram requests belong to another controller and are never accepted here
    assign req_ready = (state == smp_idle) && !reset && !req_is_sdram;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= smp_idle;
            count <= '0;
            cur_write <= 1'b0;
            cur_bank <= 1'b0;
            cur_lanes <= smp_lanes_none;
        end
        else
        begin
            unique case (state)
                smp_idle:
                begin
                    if (req_valid && req_ready)
                    begin
                        state <= smp_active;
                        count <= (req_wait_cycles == '0) ? cnt_w'(smp_cnt_one) : req_wait_cycles;
                        cur_write <= req_write;
                        cur_bank <= req_addr[smp_bank_bit];
                        // boot bank static accesses (not I/O) narrow lanes to the strapped width
                        cur_lanes <= (!req_is_io && !req_addr[smp_bank_bit]) ?
                            (req_byte_en & boot_lane_mask) : req_byte_en;
                    end
                end
                smp_active:
                begin
                    if (count > cnt_w'(smp_cnt_one))
                        count <= count - cnt_w'(smp_cnt_one);
                    else if (wait_s2)
                        state <= smp_done;
                end
                smp_done:
                    state <= smp_idle;
                default:
                    state <= smp_idle;
            endcase
        end
    end

    assign done = (state == smp_done);

    always_ff @(posedge clk)
    begin
        if (reset || state != smp_active)
        begin
            static_bank_select_n <= 2'h3;
            static_output_enable_n_out <= 1'b1;
            byte_lane_write_strobe_n <= 4'hf;
        end
        else
        begin
            static_bank_select_n <= ~(2'h1 << cur_bank);
            static_output_enable_n_out <= cur_write;
            byte_lane_write_strobe_n <= cur_write ? ~cur_lanes : 4'hf;
        end
    end

    // pins float during reset so the board straps can be read
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            static_output_enable_n_oe <= 1'b0;
            indicator_oe <= 2'h0;
            indicator_out <= 2'h0;
        end
        else
        begin
            static_output_enable_n_oe <= 1'b1;
            indicator_oe <= 2'h3;
            indicator_out <= led_drive;
        end
    end
endmodule : smp_static_pins
`default_nettype wire

// ===== rtl/smp_strap_if.sv
/*
 * smp_strap_if: carries the latched reset straps between the strap sampler and the top.
 * Assumes both ends share clk.
 */
`timescale 1ns/10ps
`default_nettype none
interface smp_strap_if;
    logic wdog_reset_polarity_strap;
    logic [1:0] boot_bank_width_strap;
    logic width_reserved;
    modport sampler (output wdog_reset_polarity_strap, output boot_bank_width_strap,
        output width_reserved);
    modport user (input wdog_reset_polarity_strap, input boot_bank_width_strap,
        input width_reserved);
endinterface : smp_strap_if
`default_nettype wire

// ===== rtl/smp_strap_sampler.sv
/*
 * smp_strap_sampler: catches the strap pins while reset is held and freezes them after.
 * Assumes strap pins are synchronised by the caller and the board drives them in reset.
 */
`timescale 1ns/10ps
`default_nettype none
module smp_strap_sampler
    import smp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic oe_pin_sync,
    input wire logic [1:0] led_pins_sync,
    smp_strap_if.sampler straps
);
    // clocked while reset is high, so the last value before release is kept
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            straps.wdog_reset_polarity_strap <= oe_pin_sync;
            straps.boot_bank_width_strap <= led_pins_sync;
        end
    end

    assign straps.width_reserved = (straps.boot_bank_width_strap == smp_width_rsvd);
endmodule : smp_strap_sampler
`default_nettype wire

// ===== sim/smp_ext_dev.sv
/* smp_ext_dev: static device; bank 1 asks for more cycles. Assumes a pull-up on wait. */
`timescale 1ns/10ps
`default_nettype none
module smp_ext_dev
(
    input wire logic clk,
    input wire logic [1:0] sel_n,
    output logic ext_wait_n
);
    logic [3:0] cnt;
    always_ff @(posedge clk)
        cnt <= sel_n == 2'h3 ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
    assign ext_wait_n = sel_n[1] || cnt >= 4'h6;
endmodule : smp_ext_dev
`default_nettype wire

// ===== sim/smp_static_props.sv
/* smp_static_props: checker on the pin control ports; assumes a bind to smp_static_pins. */
`timescale 1ns/10ps
`default_nettype none
module smp_static_props
(
    input wire logic clk,
    input wire logic reset,
    input wire logic done,
    input wire logic ext_wait_n,
    input wire logic [1:0] static_bank_select_n,
    input wire logic static_output_enable_n_out,
    input wire logic static_output_enable_n_oe,
    input wire logic [3:0] byte_lane_write_strobe_n,
    input wire logic wdog_reset_polarity_strap,
    input wire logic [1:0] boot_bank_width_strap,
    input wire logic [3:0] boot_lane_mask
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_busy;
        static_bank_select_n != 2'h3;
    endsequence
    a_one_bank: assert property (static_bank_select_n != 2'h0) else $error("bank clash");
    a_oe_access: assert property (!static_output_enable_n_out |-> s_busy) else $error("oe idle");
    a_read_quiet: assert property (!static_output_enable_n_out |-> &byte_lane_write_strobe_n)
        else $error("strobe in read");
    a_wait_stretch: assert property (!ext_wait_n [*3] ##0 s_busy |=> s_busy)
        else $error("wait ignored");
    a_strap_hold: assert property ($past(!reset) |->
        $stable({wdog_reset_polarity_strap, boot_bank_width_strap})) else $error("strap moved");
    a_oe_pin_out: assert property ($past(!reset) |-> static_output_enable_n_oe)
        else $error("oe pin not driven");
    a_lane_map: assert property ($past(!reset) |-> boot_lane_mask ==
        {{2{~^boot_bank_width_strap}}, boot_bank_width_strap != 2'h1, 1'b1}) else $error("lanes");
    a_done_pulse: assert property (done |=> (static_bank_select_n == 2'h3) && !done)
        else $error("done long");
endmodule : smp_static_props
`default_nettype wire

// ===== sim/testbench.sv
/* testbench: straps and static accesses; assumes smp_ext_dev on the wait pin. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'h0, reset = 1'h1, req_valid = 1'h0, req_write = 1'h0, req_is_io = 1'h0;
    logic req_is_sdram = 1'h0, static_output_enable_n_in = 1'h0;
    logic [25:0] req_addr = 26'h0;
    logic [3:0] req_byte_en = 4'h0, req_wait_cycles = 4'h4;
    logic [1:0] indicator_in = 2'h0, led_drive = 2'h2;
    logic req_ready, done, ext_wait_n, static_output_enable_n_out, static_output_enable_n_oe;
    logic wdog_reset_polarity_strap, boot_width_reserved;
    logic [1:0] static_bank_select_n, indicator_out, indicator_oe, boot_bank_width_strap;
    logic [3:0] byte_lane_write_strobe_n, boot_lane_mask;
    int num_errors = 0, total_checks = 0, cycles = 0;
    smp_static_pins u_smp_static_pins (.*);
    smp_ext_dev u_smp_ext_dev (.clk, .sel_n(static_bank_select_n), .ext_wait_n);
    always #50 clk = ~clk;
    always @(posedge clk)
        if (++cycles == 3000)
            end_sim(1);
    task chk(string nm, logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_sim(int late = 0);
        num_errors += late;
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic straps(logic [1:0] w);
        @(posedge clk);
        {reset, static_output_enable_n_in, indicator_in} <= {1'h1, w[0], w};
        repeat (9) @(posedge clk);
        @(negedge clk);
        chk("oe_en", 8'(static_output_enable_n_oe), 8'h0);
        chk("led_en", 8'(indicator_oe), 8'h0);
        @(posedge clk);
        {reset, static_output_enable_n_in, indicator_in, led_drive} <= {1'h0, ~w[0], ~w, w};
        repeat (3) @(negedge clk);
        chk("oe_en", 8'(static_output_enable_n_oe), 8'h1);
        chk("led_en", 8'(indicator_oe), 8'h3);
        chk("led", 8'(indicator_out), 8'(w));
        chk("pol", 8'(wdog_reset_polarity_strap), 8'(w[0]));
        chk("width", 8'(boot_bank_width_strap), 8'(w));
        chk("rsvd", 8'(boot_width_reserved), 8'(w == 2'h0));
    endtask : straps
    task automatic acc(logic b, wr, sd, io, logic [3:0] be, ln);
        int k = 0;
        logic d = 1'h0;
        @(posedge clk);
        {req_valid, req_addr[25], req_write} <= {1'h1, b, wr};
        {req_is_sdram, req_is_io, req_byte_en} <= {sd, io, be};
        do @(negedge clk); while (req_ready !== 1'h1 && ++k < 9);
        @(posedge clk);
        req_valid <= 1'h0;
        do @(negedge clk); while (static_bank_select_n === 2'h3 && ++k < 18);
        chk("sel", 8'(static_bank_select_n), sd ? 8'h3 : b ? 8'h1 : 8'h2);
        if (sd)
        begin
            chk("rdy", 8'(req_ready), 8'h0);
            return;
        end
        chk("oe", 8'(static_output_enable_n_out), 8'(wr));
        chk("we", 8'(byte_lane_write_strobe_n), {4'h0, ~ln});
        for (k = 0; static_bank_select_n !== 2'h3 && k < 20; k++)
        begin
            d = done;
            @(negedge clk);
        end
        chk("len", 8'(k >= (b ? 7 : 3)), 8'h1);
        chk("done", 8'(d), 8'h1);
        chk("done_end", 8'(done), 8'h0);
    endtask : acc
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            straps(2'(i + 1));
            acc(1'h0, 1'h1, 1'h0, 1'h0, 4'hf, i == 0 ? 4'h1 : i == 1 ? 4'h3 : 4'hf);
            acc(1'h0, 1'h1, 1'h0, 1'h1, 4'h5, 4'h5);
        end
        acc(1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 4'h0);
        acc(1'h1, 1'h1, 1'h0, 1'h0, 4'h6, 4'h6);
        acc(1'h0, 1'h1, 1'h1, 1'h0, 4'hf, 4'hf);
        end_sim();
    end
endmodule : testbench
bind smp_static_pins smp_static_props u_smp_static_props (.*);
`default_nettype wire
